// *** irq_sources.sv ***
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
// Function
// - Top reset-cause bit enables two priority levels
// - Reset-cause bits four to zero record cause
// - External inputs edge sensitive, polarity per select
// - Selected edge sets flag regardless of enable
// - Clear enable blocks request, flag still sets
// - Enabled external interrupt wakes power-managed mode
// - Vector after wake needs global enable; low priority with levels enabled needs only first bit6
// - External one/two priority in third control
// - External zero always high priority
// - Eight-bit timer rollover sets overflow flag
// - Sixteen-bit timer rollover sets overflow flag
// - Timer enable first bit5, priority second bit2
// - Upper nibble change sets port change flag
// - Port change enable bit3, priority bit0
// - Accept pushes return address on stack
// - Accept copies work, status, bank to fast
// - Priority bits act only with levels enabled
// - Change compares with last-read latched value; code latches on any access to the port address, writes included
module irq_sources (
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic [7:0]           paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [2:0]           extIrqPins,
  input  wire logic [7:0]           changePortPins,
  input  wire logic                 sleepMode,
  input  wire logic                 acceptIrq,
  input  wire logic                 retfie,
  input  wire logic [15:0]          returnPc,
  input  wire irq_pkg::context_type coreContext,
  input  wire logic [4:0]           resetCauseIn,
  input  wire logic                 resetCauseLoad,
  output logic                      irqRequest,
  output logic [15:0]               irqVector,
  output logic                      wakeUp
);
  import irq_pkg::*;

  localparam int STACK_DEPTH = 8;
  initial begin
    if (STACK_DEPTH < 2 || STACK_DEPTH > 16) $error("stack depth unsupported");
  end

  // ************************************************************
  // Pin synchronisers and edge detection
  // ************************************************************
  logic [2:0]  extMeta_r, extSync_r, extOld_r;
  logic [7:4]  chgMeta_r, chgSync_r;
  logic [2:0]  edgeHit;
  logic [7:0]  ctrl1_r, ctrl2_r, ctrl3_r, rcause_r;
  logic [2:0]  edgeSel;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      extMeta_r <= 3'h0;
      extSync_r <= 3'h0;
      extOld_r  <= 3'h0;
      chgMeta_r <= 4'h0;
      chgSync_r <= 4'h0;
    end else begin
      extMeta_r <= extIrqPins;
      extSync_r <= extMeta_r;
      extOld_r  <= extSync_r;
      chgMeta_r <= changePortPins[7:4];
      chgSync_r <= chgMeta_r;
    end
  end

  assign edgeSel = {ctrl2_r[C2_EDG2], ctrl2_r[C2_EDG1], ctrl2_r[C2_EDG0]};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : gEdge
      // Rising when select set, falling when clear
      assign edgeHit[gi] = edgeSel[gi] ? (extSync_r[gi] & ~extOld_r[gi])
                                       : (~extSync_r[gi] & extOld_r[gi]);
    end
  endgenerate

  // ************************************************************
  // APB decode
  // ************************************************************
  logic wrEn, rdEn, known;
  // Writes land only at the edge where the master sees pready
  assign wrEn = psel & penable & pwrite & pready;
  assign rdEn = psel & penable & ~pwrite;
  always_comb begin
    case (paddr)
      ADDR_CTRL1, ADDR_CTRL2, ADDR_CTRL3, ADDR_RCAUSE, ADDR_PORT,
      ADDR_TMR, ADDR_CTX, ADDR_FAST, ADDR_STACK: known = 1'b1;
      default: known = 1'b0;
    endcase
  end

  // ************************************************************
  // Timer0
  // ************************************************************
  logic [15:0] tmrCount_r;
  logic        tmrWide_r, tmrRun_r, tmrOvf;
  logic [15:0] tmrMax;
  assign tmrMax = tmrWide_r ? T16_MAX : T8_MAX;
  assign tmrOvf = tmrRun_r && tmrCount_r == tmrMax;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tmrCount_r <= 16'h0000;
      tmrWide_r  <= 1'b0;
      tmrRun_r   <= 1'b0;
    end else if (wrEn && paddr == ADDR_TMR) begin
      tmrCount_r <= pwdata[15:0];
      tmrWide_r  <= pwdata[TM_W16];
      tmrRun_r   <= pwdata[TM_RUN];
    end else if (tmrRun_r) begin
      tmrCount_r <= tmrOvf ? 16'h0000 : tmrCount_r + 16'h0001;
    end
  end

  // ************************************************************
  // Port change latch and mismatch
  // ************************************************************
  logic [7:4] chgLatch_r;
  logic       chgMismatch;
  assign chgMismatch = |(chgSync_r ^ chgLatch_r);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      chgLatch_r <= 4'h0;
    end else if (psel && penable && paddr == ADDR_PORT) begin
      chgLatch_r <= chgSync_r;
    end
  end

  // ************************************************************
  // Control registers; hardware set wins over software clear
  // ************************************************************
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl1_r <= CTRL1_RST;
    end else begin
      if (wrEn && paddr == ADDR_CTRL1) begin
        ctrl1_r <= pwdata[7:0];
      end
      if (edgeHit[0]) begin
        ctrl1_r[C1_E0IF] <= 1'b1;
      end
      if (tmrOvf) begin
        ctrl1_r[C1_T0IF] <= 1'b1;
      end
      if (chgMismatch) begin
        ctrl1_r[C1_PCIF] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl2_r <= CTRL2_RST;
    end else if (wrEn && paddr == ADDR_CTRL2) begin
      ctrl2_r <= pwdata[7:0] & CTRL2_MASK;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl3_r <= CTRL3_RST;
    end else begin
      if (wrEn && paddr == ADDR_CTRL3) begin
        ctrl3_r <= pwdata[7:0] & CTRL3_MASK;
      end
      if (edgeHit[1]) begin
        ctrl3_r[C3_E1IF] <= 1'b1;
      end
      if (edgeHit[2]) begin
        ctrl3_r[C3_E2IF] <= 1'b1;
      end
    end
  end

  // Cause bits loaded by the reset manager; software may clear writable ones
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rcause_r <= RCAUSE_RST;
    end else if (resetCauseLoad) begin
      rcause_r <= {rcause_r[RC_PRIORITY_LEVELS_ENABLE], 2'b00, resetCauseIn};
    end else if (wrEn && paddr == ADDR_RCAUSE) begin
      rcause_r <= (pwdata[7:0] & RCAUSE_WMASK) | (rcause_r & ~RCAUSE_WMASK & 8'h1F);
    end
  end

  // ************************************************************
  // Request arbitration
  // ************************************************************
  logic [2:0] extPend;
  logic       tmrPend, chgPend, priority_levels_enable, anyHigh, anyLow, anyPend;
  logic       prioE1, prioE2, prioT0, prioPc;
  level_type  active_r;
  assign priority_levels_enable    = rcause_r[RC_PRIORITY_LEVELS_ENABLE];
  assign extPend = {ctrl3_r[C3_E2IF] & ctrl3_r[C3_E2IE],
                    ctrl3_r[C3_E1IF] & ctrl3_r[C3_E1IE],
                    ctrl1_r[C1_E0IF] & ctrl1_r[C1_E0IE]};
  assign tmrPend = ctrl1_r[C1_T0IF] & ctrl1_r[C1_T0IE];
  assign chgPend = ctrl1_r[C1_PCIF] & ctrl1_r[C1_PCIE];
  assign prioE1  = ctrl3_r[C3_E1IP];
  assign prioE2  = ctrl3_r[C3_E2IP];
  assign prioT0  = ctrl2_r[C2_T0IP];
  assign prioPc  = ctrl2_r[C2_PCIP];
  assign anyPend = |extPend | tmrPend | chgPend;
  assign anyHigh = extPend[0] | (extPend[1] & prioE1) | (extPend[2] & prioE2)
                 | (tmrPend & prioT0) | (chgPend & prioPc);
  assign anyLow  = anyPend & ~(extPend[0] | (extPend[1] & prioE1)
                 | (extPend[2] & prioE2) | (tmrPend & prioT0) | (chgPend & prioPc));

  logic reqNxt;
  logic [15:0] vecNxt;
  always_comb begin
    reqNxt = 1'b0;
    vecNxt = VEC_HIGH;
    if (!priority_levels_enable) begin
      reqNxt = anyPend && ctrl1_r[C1_GIE] && active_r == LVL_NONE;
    end else if (anyHigh && ctrl1_r[C1_GIE] && active_r != LVL_HIGH) begin
      reqNxt = 1'b1;
    end else if (anyLow && ctrl1_r[C1_PEIE] && active_r == LVL_NONE) begin
      reqNxt = 1'b1;
      vecNxt = VEC_LOW;
    end
  end

  // Active level tracks nesting; one level of preemption only
  level_type outer_r;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      active_r <= LVL_NONE;
      outer_r  <= LVL_NONE;
    end else if (acceptIrq && irqRequest) begin
      outer_r  <= active_r;
      active_r <= (priority_levels_enable && irqVector == VEC_LOW) ? LVL_LOW : LVL_HIGH;
    end else if (retfie) begin
      active_r <= outer_r;
      outer_r  <= LVL_NONE;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irqRequest <= 1'b0;
      irqVector  <= VEC_HIGH;
      wakeUp     <= 1'b0;
    end else begin
      irqRequest <= reqNxt & ~(acceptIrq & irqRequest);
      irqVector  <= vecNxt;
      // Enables alone gate wake; global enable only decides vectoring
      wakeUp     <= sleepMode & (|extPend | tmrPend | chgPend);
    end
  end

  // ************************************************************
  // Return stack and fast context
  // ************************************************************
  logic [15:0] stack_r [STACK_DEPTH];
  logic [3:0]  sp_r;
  context_type fast_r;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sp_r <= 4'h0;
    end else if (acceptIrq && irqRequest && sp_r < 4'(STACK_DEPTH)) begin
      stack_r[sp_r[2:0]] <= returnPc;
      sp_r <= sp_r + 4'h1;
    end else if (retfie && sp_r != 4'h0) begin
      sp_r <= sp_r - 4'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fast_r <= '0;
    end else if (acceptIrq && irqRequest) begin
      fast_r <= coreContext;
    end
  end

  // ************************************************************
  // APB read and response
  // ************************************************************
  logic [31:0] rdNxt;
  logic [15:0] topPc;
  assign topPc = (sp_r == 4'h0) ? 16'h0000 : stack_r[3'(sp_r - 4'h1)];
  always_comb begin
    case (paddr)
      ADDR_CTRL1:  rdNxt = {24'h0, ctrl1_r};
      ADDR_CTRL2:  rdNxt = {24'h0, ctrl2_r};
      ADDR_CTRL3:  rdNxt = {24'h0, ctrl3_r};
      ADDR_RCAUSE: rdNxt = {24'h0, rcause_r};
      ADDR_PORT:   rdNxt = {24'h0, chgSync_r, 4'h0};
      ADDR_TMR:    rdNxt = {14'h0, tmrRun_r, tmrWide_r, tmrCount_r};
      ADDR_CTX:    rdNxt = {30'h0, active_r};
      ADDR_FAST:   rdNxt = {8'h0, fast_r};
      ADDR_STACK:  rdNxt = {12'h0, sp_r, topPc};
      default:     rdNxt = 32'h0;
    endcase
  end

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~known;
      prdata  <= (rdEn && !pready) ? rdNxt : 32'h0;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  rising_edge_a: assert property (@(posedge clock) disable iff (!rst_n)
    (extSync_r[1] && !extOld_r[1] && ctrl2_r[C2_EDG1]) |=> ctrl3_r[C3_E1IF])
    else $error("rising edge did not set flag");
  falling_edge_a: assert property (@(posedge clock) disable iff (!rst_n)
    (!extSync_r[0] && extOld_r[0] && !ctrl2_r[C2_EDG0]) |=> ctrl1_r[C1_E0IF])
    else $error("falling edge did not set flag");
  disabled_quiet_a: assert property (@(posedge clock) disable iff (!rst_n)
    (!ctrl1_r[C1_E0IE] && !tmrPend && !chgPend && extPend[2:1] == 2'b00) |=> !irqRequest)
    else $error("disabled source requested");
  timer_ovf_a: assert property (@(posedge clock) disable iff (!rst_n)
    (tmrRun_r && !tmrWide_r && tmrCount_r == 16'h00FF && !(wrEn && paddr == ADDR_TMR))
    |=> (tmrCount_r == 16'h0000 && ctrl1_r[C1_T0IF]))
    else $error("8-bit overflow missed");
  change_flag_a: assert property (@(posedge clock) disable iff (!rst_n)
    chgMismatch |=> ctrl1_r[C1_PCIF])
    else $error("port change not flagged");
  wake_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
    (sleepMode && extPend[0]) |=> wakeUp)
    else $error("no wake on enabled edge");
  no_vector_a: assert property (@(posedge clock) disable iff (!rst_n)
    (!ctrl1_r[C1_GIE] && !priority_levels_enable) |=> !irqRequest)
    else $error("vector with global disabled");
  ext0_high_a: assert property (@(posedge clock) disable iff (!rst_n)
    (priority_levels_enable && extPend[0] && ctrl1_r[C1_GIE] && active_r == LVL_NONE) |=> irqVector == VEC_HIGH)
    else $error("external zero not high");
  fast_save_a: assert property (@(posedge clock) disable iff (!rst_n)
    (acceptIrq && irqRequest) |=> fast_r == $past(coreContext))
    else $error("fast context not saved");
  stack_push_a: assert property (@(posedge clock) disable iff (!rst_n)
    (acceptIrq && irqRequest && sp_r < 4'(STACK_DEPTH)) |=> sp_r == $past(sp_r) + 4'h1)
    else $error("return address not pushed");
  apb_ready_a: assert property (@(posedge clock) disable iff (!rst_n)
    (psel && !penable) ##1 (psel && penable) |=> pready)
    else $error("pready late");
endmodule

// *** irq_pkg.sv ***
package irq_pkg;

  // ************************************************************
  // Register map (byte addresses on APB)
  // ************************************************************
  localparam logic [7:0] ADDR_CTRL1  = 8'h00;
  localparam logic [7:0] ADDR_CTRL2  = 8'h04;
  localparam logic [7:0] ADDR_CTRL3  = 8'h08;
  localparam logic [7:0] ADDR_RCAUSE = 8'h0C;
  localparam logic [7:0] ADDR_PORT   = 8'h10;
  localparam logic [7:0] ADDR_TMR    = 8'h14;
  localparam logic [7:0] ADDR_CTX    = 8'h18;
  localparam logic [7:0] ADDR_FAST   = 8'h1C;
  localparam logic [7:0] ADDR_STACK  = 8'h20;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int C1_GIE  = 7;
  localparam int C1_PEIE = 6;
  localparam int C1_T0IE = 5;
  localparam int C1_E0IE = 4;
  localparam int C1_PCIE = 3;
  localparam int C1_T0IF = 2;
  localparam int C1_E0IF = 1;
  localparam int C1_PCIF = 0;
  localparam int C2_EDG0 = 6;
  localparam int C2_EDG1 = 5;
  localparam int C2_EDG2 = 4;
  localparam int C2_T0IP = 2;
  localparam int C2_PCIP = 0;
  localparam int C3_E2IP = 7;
  localparam int C3_E1IP = 6;
  localparam int C3_E2IE = 4;
  localparam int C3_E1IE = 3;
  localparam int C3_E2IF = 1;
  localparam int C3_E1IF = 0;
  localparam int RC_PRIORITY_LEVELS_ENABLE = 7;
  localparam int TM_W16  = 16;
  localparam int TM_RUN  = 17;

  // ************************************************************
  // Reset values and write masks
  // ************************************************************
  localparam logic [7:0] CTRL1_RST  = 8'h00;
  localparam logic [7:0] CTRL2_RST  = 8'hF5;
  localparam logic [7:0] CTRL3_RST  = 8'hC0;
  localparam logic [7:0] RCAUSE_RST = 8'h1C;
  localparam logic [7:0] CTRL2_MASK = 8'hF5;
  localparam logic [7:0] CTRL3_MASK = 8'hDB;
  localparam logic [7:0] RCAUSE_WMASK = 8'h93;

  localparam logic [15:0] T8_MAX  = 16'h00FF;
  localparam logic [15:0] T16_MAX = 16'hFFFF;

  localparam logic [15:0] VEC_HIGH = 16'h0008;
  localparam logic [15:0] VEC_LOW  = 16'h0018;

  typedef struct packed {
    logic [7:0]  workReg;
    logic [7:0]  statusReg;
    logic [7:0]  bankReg;
  } context_type;

  typedef enum logic [1:0] {
    LVL_NONE = 2'b00,
    LVL_LOW  = 2'b01,
    LVL_HIGH = 2'b10
  } level_type;

endpackage

// *** irq_core_model.sv ***
`timescale 1ns/1ps
module irq_core_model (
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic                 irqRequest,
  input  wire logic [15:0]          irqVector,
  input  wire logic                 allow,
  input  wire logic [3:0]           latency,
  input  wire logic                 retReq,
  output logic                      acceptIrq,
  output logic                      retfie,
  output logic [15:0]               returnPc,
  output irq_pkg::context_type      coreContext,
  output logic [15:0]               accVec,
  output logic [15:0]               accPc,
  output irq_pkg::context_type      accCtx,
  output int                        accCnt
);
  import irq_pkg::*;
  logic [3:0] waitCnt_r;

  // Pc keeps moving so a late or early capture shows up
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      returnPc <= 16'h0100;
    end else begin
      returnPc <= returnPc + 16'h0002;
    end
  end
  assign coreContext = {returnPc[7:0], ~returnPc[7:0], returnPc[15:8] ^ 8'h5A};

  // Capture at the edge the design samples acceptIrq
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      acceptIrq <= 1'b0;
      waitCnt_r <= 4'h0;
      accCnt    <= 0;
      accVec    <= 16'h0000;
      accPc     <= 16'h0000;
      accCtx    <= '0;
    end else if (acceptIrq) begin
      acceptIrq <= 1'b0;
      waitCnt_r <= 4'h0;
      accCnt    <= accCnt + 1;
      accVec    <= irqVector;
      accPc     <= returnPc;
      accCtx    <= coreContext;
    end else if (allow && irqRequest) begin
      if (waitCnt_r >= latency) begin
        acceptIrq <= 1'b1;
      end else begin
        waitCnt_r <= waitCnt_r + 4'h1;
      end
    end else begin
      waitCnt_r <= 4'h0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      retfie <= 1'b0;
    end else begin
      retfie <= retReq;
    end
  end
endmodule

// *** test_irq_sources.sv ***
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin error_cnt++; $display("MISMATCH %s exp %h got %h", nm, ex, gt); end end
module test_irq_sources;
  import irq_pkg::*;
  logic        clock, rst_n, psel, penable, pwrite, pready, pslverr, errv;
  logic        sleepMode, resetCauseLoad, acceptIrq, retfie, irqRequest, wakeUp;
  logic        allow, retReq, fb;
  logic [7:0]  paddr, changePortPins, ad, dv;
  logic [31:0] pwdata, prdata, rdv, r;
  logic [2:0]  extIrqPins;
  logic [4:0]  resetCauseIn;
  logic [3:0]  latency;
  logic [15:0] returnPc, irqVector, accVec, accPc;
  context_type coreContext, accCtx;
  int          accCnt, error_cnt, cmp_count, cyc, seed;
  logic [15:0] expVec[$];
  logic [7:0]  ra[4] = '{ADDR_CTRL1, ADDR_CTRL2, ADDR_CTRL3, ADDR_RCAUSE};
  logic [7:0]  rv[4] = '{CTRL1_RST, CTRL2_RST, CTRL3_RST, RCAUSE_RST};

  irq_sources u_irq_sources (.clock(clock), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .extIrqPins(extIrqPins), .changePortPins(changePortPins),
    .sleepMode(sleepMode), .acceptIrq(acceptIrq), .retfie(retfie), .returnPc(returnPc),
    .coreContext(coreContext), .resetCauseIn(resetCauseIn), .resetCauseLoad(resetCauseLoad),
    .irqRequest(irqRequest), .irqVector(irqVector), .wakeUp(wakeUp));
  irq_core_model u_irq_core_model (.clock(clock), .rst_n(rst_n), .irqRequest(irqRequest),
    .irqVector(irqVector), .allow(allow), .latency(latency), .retReq(retReq),
    .acceptIrq(acceptIrq), .retfie(retfie), .returnPc(returnPc), .coreContext(coreContext),
    .accVec(accVec), .accPc(accPc), .accCtx(accCtx), .accCnt(accCnt));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ************************************************************
  // Bus, pin and core helpers
  // ************************************************************
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic pins(input logic [2:0] e, input logic [7:0] c);
    extIrqPins <= e;
    changePortPins <= c;
    repeat (6) @(posedge clock);
  endtask

  // Read flag of external line i into fb
  task automatic getf(input int i);
    apb(1'b0, (i == 0) ? ADDR_CTRL1 : ADDR_CTRL3, 32'h0);
    fb = (i == 0) ? rdv[C1_E0IF] : rdv[i - 1];
  endtask

  task automatic serve(input logic [15:0] v, input int n);
    int k;
    expVec.push_back(v);
    for (k = 0; k < 60 && accCnt < n; k++) @(posedge clock);
    `CHK("accept count", n, accCnt)
    `CHK("vector", expVec.pop_front(), accVec)
    apb(1'b0, ADDR_STACK, 32'h0);
    `CHK("stack pc", accPc, rdv[15:0])
    apb(1'b0, ADDR_FAST, 32'h0);
    `CHK("fast ctx", accCtx, context_type'(rdv[23:0]))
  endtask

  task automatic ret();
    retReq <= 1'b1;
    @(posedge clock);
    retReq <= 1'b0;
    @(posedge clock);
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end

  initial begin
    {rst_n, psel, penable, pwrite, sleepMode, resetCauseLoad, allow, retReq} = '0;
    {paddr, pwdata, extIrqPins, changePortPins, resetCauseIn} = '0;
    {error_cnt, cmp_count, cyc} = '0;
    seed = 32'hBA1BD8CD;
    latency = 4'h0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, ra[i], 32'h0);
      `CHK("reset value", {24'h0, rv[i]}, rdv)
    end
    apb(1'b0, 8'h30, 32'h0);
    `CHK("unmapped err", 1'b1, errv)
    apb(1'b1, ADDR_RCAUSE, 32'hFF);
    apb(1'b0, ADDR_RCAUSE, 32'h0);
    `CHK("cause write", 32'h9F, rdv)
    r = $random(seed);
    resetCauseIn <= r[4:0];
    resetCauseLoad <= 1'b1;
    @(posedge clock);
    resetCauseLoad <= 1'b0;
    @(posedge clock);
    apb(1'b0, ADDR_RCAUSE, 32'h0);
    `CHK("cause load", {24'h0, 3'b100, r[4:0]}, rdv)
    $display("test reset_cause done");
    for (int i = 0; i < 3; i++) begin
      for (int p = 0; p < 2; p++) begin
        dv = (CTRL2_RST & ~(8'h40 >> i)) | (8'(p) << (6 - i));
        apb(1'b1, ADDR_CTRL2, {24'h0, dv});
        pins(extIrqPins ^ ((3'(p) ^ extIrqPins[i]) ? 3'(1 << i) : 3'h0), changePortPins);
        apb(1'b1, ADDR_CTRL1, 32'hC0);
        apb(1'b1, ADDR_CTRL3, 32'hC0);
        pins(extIrqPins ^ 3'(1 << i), changePortPins);
        getf(i);
        `CHK("wrong edge", 1'b0, fb)
        pins(extIrqPins ^ 3'(1 << i), changePortPins);
        getf(i);
        `CHK("right edge", 1'b1, fb)
        repeat (10) @(posedge clock);
        getf(i);
        `CHK("flag held", 1'b1, fb)
        `CHK("disabled req", 1'b0, irqRequest)
      end
    end
    $display("test ext_edges done");
    apb(1'b1, ADDR_CTRL1, 32'h0);
    apb(1'b1, ADDR_TMR, 32'h000200FD);
    repeat (8) @(posedge clock);
    apb(1'b0, ADDR_CTRL1, 32'h0);
    `CHK("t8 overflow", 1'b1, rdv[C1_T0IF])
    apb(1'b1, ADDR_TMR, 32'h0);
    apb(1'b1, ADDR_CTRL1, 32'h0);
    apb(1'b1, ADDR_TMR, 32'h000300FD);
    repeat (8) @(posedge clock);
    apb(1'b0, ADDR_CTRL1, 32'h0);
    `CHK("t16 no ovf", 1'b0, rdv[C1_T0IF])
    apb(1'b1, ADDR_TMR, 32'h0003FFFD);
    repeat (8) @(posedge clock);
    apb(1'b0, ADDR_CTRL1, 32'h0);
    `CHK("t16 overflow", 1'b1, rdv[C1_T0IF])
    apb(1'b1, ADDR_TMR, 32'h0);
    $display("test timer done");
    for (int k = 0; k < 4; k++) begin
      apb(1'b0, ADDR_PORT, 32'h0);
      apb(1'b1, ADDR_CTRL1, 32'h0);
      r = $random(seed);
      pins(extIrqPins, changePortPins ^ {4'h0, r[3:0]});
      apb(1'b0, ADDR_CTRL1, 32'h0);
      `CHK("low nibble", 1'b0, rdv[C1_PCIF])
      pins(extIrqPins, changePortPins ^ (8'h10 << k));
      apb(1'b0, ADDR_CTRL1, 32'h0);
      `CHK("high nibble", 1'b1, rdv[C1_PCIF])
    end
    apb(1'b0, ADDR_PORT, 32'h0);
    apb(1'b1, ADDR_CTRL1, 32'h0);
    apb(1'b0, ADDR_CTRL1, 32'h0);
    `CHK("relatched", 1'b0, rdv[C1_PCIF])
    apb(1'b0, ADDR_PORT, 32'h0);
    `CHK("port value", {24'h0, changePortPins[7:4], 4'h0}, rdv)
    $display("test port_change done");
    allow <= 1'b1;
    latency <= 4'($unsigned($random(seed)) % 4);
    apb(1'b1, ADDR_CTRL2, {24'h0, CTRL2_RST});
    pins(3'h0, changePortPins);
    apb(1'b1, ADDR_CTRL3, 32'hC0);
    apb(1'b1, ADDR_CTRL1, 32'h90);
    pins(3'h1, changePortPins);
    serve(VEC_HIGH, 1);
    apb(1'b1, ADDR_CTRL1, 32'h00);
    ret();
    apb(1'b1, ADDR_RCAUSE, 32'h00);
    apb(1'b1, ADDR_CTRL2, 32'hF1);
    apb(1'b1, ADDR_CTRL1, 32'hA0);
    apb(1'b1, ADDR_TMR, 32'h000200FD);
    serve(VEC_HIGH, 2);
    apb(1'b1, ADDR_TMR, 32'h0);
    apb(1'b1, ADDR_CTRL1, 32'h0);
    ret();
    apb(1'b1, ADDR_RCAUSE, 32'h80);
    apb(1'b1, ADDR_CTRL2, 32'hF1);
    pins(3'h0, changePortPins);
    apb(1'b1, ADDR_CTRL1, 32'hF0);
    apb(1'b1, ADDR_TMR, 32'h000200FD);
    serve(VEC_LOW, 3);
    apb(1'b1, ADDR_TMR, 32'h0);
    pins(3'h1, changePortPins);
    serve(VEC_HIGH, 4);
    apb(1'b0, ADDR_CTX, 32'h0);
    `CHK("nest high", {30'h0, LVL_HIGH}, rdv)
    apb(1'b1, ADDR_CTRL1, 32'h0);
    ret();
    apb(1'b0, ADDR_CTX, 32'h0);
    `CHK("nest low", {30'h0, LVL_LOW}, rdv)
    ret();
    $display("test service done");
    allow <= 1'b0;
    apb(1'b1, ADDR_CTRL3, 32'hC8);
    sleepMode <= 1'b1;
    pins(3'h3, changePortPins);
    `CHK("wake", 1'b1, wakeUp)
    `CHK("no vector", 1'b0, irqRequest)
    apb(1'b1, ADDR_CTRL3, 32'hC0);
    pins(3'h1, changePortPins);
    pins(3'h3, changePortPins);
    `CHK("no wake", 1'b0, wakeUp)
    $display("test wake done");
    close_out();
  end
endmodule
